// [uam_top.sv]
`timescale 1ns/100ps
`include "uam_map.svh"
module uam_top import uam_pkg::*; #(
    parameter int DEPTH       = `UAM_FIFO_DEPTH,
    parameter bit HALF_DUPLEX = 1'b0
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           ovs_sixteen,
    input  wire uam_addr_mode_e addr_mode,
    input  wire logic [7:0]     rx_addr1,
    input  wire logic [7:0]     rx_addr2,
    input  wire logic           break_enable,
    input  wire logic [3:0]     break_bits,
    input  wire logic           vote_enable,
    input  wire logic           crc_enable,
    input  wire logic [6:0]     rx_int_mask,
    input  wire logic [3:0]     tx_int_mask,
    input  wire logic           tx_wr,
    input  wire logic [7:0]     tx_wdata,
    input  wire logic           tx_wmark,
    input  wire logic           tx_send_break,
    input  wire logic           rx_rd,
    input  wire logic           rx_status_clr,
    input  wire logic           rx_line,
    output logic                tx_line,
    output logic                tx_enable,
    output logic [7:0]          rx_rdata,
    output logic [6:0]          rx_status,
    output logic [3:0]          tx_status,
    output logic                rx_interrupt,
    output logic                tx_interrupt,
    output logic                tx_crc_data,
    output logic                tx_crc_clk,
    output logic                rx_crc_data,
    output logic                rx_crc_clk
);
    if (DEPTH != `UAM_FIFO_DEPTH) begin : g_depth_check
        $error("DEPTH must be four");
    end
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Bit timing and shared FIFO bookkeeping.
    // ****************************************************************
    logic [3:0] ovs_top;
    logic [7:0] txq [DEPTH];
    logic       txq_mark [DEPTH];
    logic [7:0] rxq [DEPTH];
    logic [2:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
    logic [1:0] tx_rp, tx_wp, rx_rp, rx_wp;
    assign ovs_top = ovs_sixteen ? `UAM_OVS_16 : `UAM_OVS_8;

    // ****************************************************************
    // Transmitter.
    // ****************************************************************
    uam_state_e tst, next_tst;
    logic [3:0] t_sub, next_t_sub;
    logic [3:0] t_bit, next_t_bit;
    logic [7:0] t_sh, next_t_sh;
    logic       t_mk, next_t_mk;
    logic       t_done, next_t_done;
    logic       tx_pop, tx_push;
    logic       t_line_n, t_crc_c, t_crc_d;
    assign tx_push = tx_wr && (tx_cnt != 3'(DEPTH));

    always_comb begin
        next_tst = tst;
        next_t_sub = t_sub;
        next_t_bit = t_bit;
        next_t_sh = t_sh;
        next_t_mk = t_mk;
        next_t_done = t_done;
        tx_pop = 1'b0;
        t_line_n = 1'b1;
        t_crc_c = 1'b0;
        t_crc_d = t_sh[0];
        if (tst != UAM_IDLE) begin
            next_t_sub = (t_sub == ovs_top) ? 4'h0 : t_sub + 4'h1;
        end
        case (tst)
            UAM_IDLE: begin
                next_t_sub = 4'h0;
                next_t_bit = 4'h0;
                if (break_enable && tx_send_break) begin
                    next_tst = UAM_BREAK;
                    next_t_done = 1'b0;
                end else if (tx_cnt != 3'h0) begin
                    next_tst = UAM_START;
                    next_t_sh = txq[tx_rp];
                    next_t_mk = txq_mark[tx_rp];
                    next_t_done = 1'b0;
                    tx_pop = 1'b1;
                end
            end
            UAM_START: begin
                t_line_n = 1'b0;
                if (t_sub == ovs_top) next_tst = UAM_DATA;
            end
            UAM_DATA: begin
                t_line_n = t_sh[0];
                t_crc_c = crc_enable && (t_sub > (ovs_top >> 1));
                if (t_sub == ovs_top) begin
                    next_t_sh = {1'b0, t_sh[7:1]};
                    next_t_bit = t_bit + 4'h1;
                    if (t_bit == `UAM_LAST_DATA_BIT) begin
                        next_tst = (addr_mode != UAM_ADDR_NONE) ?
                                   UAM_MARK : UAM_STOP;
                    end
                end
            end
            UAM_MARK: begin
                t_line_n = t_mk;
                if (t_sub == ovs_top) next_tst = UAM_STOP;
            end
            UAM_STOP: begin
                if (t_sub == ovs_top) begin
                    next_tst = UAM_IDLE;
                    next_t_done = (tx_cnt == 3'h0);
                end
            end
            UAM_BREAK: begin
                t_line_n = 1'b0;
                if (t_sub == ovs_top) begin
                    next_t_bit = t_bit + 4'h1;
                    if (t_bit == break_bits - 4'h1) next_tst = UAM_STOP;
                end
            end
            default: next_tst = UAM_IDLE;
        endcase
        if (tx_push) next_t_done = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tst <= UAM_IDLE;
            t_sub <= 4'h0;
            t_bit <= 4'h0;
            t_sh <= 8'h00;
            t_mk <= 1'b0;
            t_done <= 1'b0;
            tx_line <= 1'b1;
            tx_crc_clk <= 1'b0;
            tx_crc_data <= 1'b0;
        end else begin
            tst <= next_tst;
            t_sub <= next_t_sub;
            t_bit <= next_t_bit;
            t_sh <= next_t_sh;
            t_mk <= next_t_mk;
            t_done <= next_t_done;
            tx_line <= t_line_n;
            tx_crc_clk <= t_crc_c;
            tx_crc_data <= t_crc_d;
        end
    end
    assign tx_enable = (tst != UAM_IDLE) || (tx_cnt != 3'h0);

    // ****************************************************************
    // Receiver with optional majority vote.
    // ****************************************************************
    uam_state_e rst_q, next_rst_q;
    logic [3:0] r_sub, next_r_sub;
    logic [3:0] r_bit, next_r_bit;
    logic [7:0] r_sh, next_r_sh;
    logic [1:0] r_smp, next_r_smp;
    logic       r_zero, next_r_zero;
    logic       r_par, next_r_par;
    logic       r_sel, next_r_sel;
    logic       r_val, r_end, r_push, r_crc_c;
    logic [3:0] mid;
    logic [6:0] ev;
    assign mid = ovs_top >> 1;
    assign r_val = vote_enable ?
        ((r_smp[0] & r_smp[1]) | (r_smp[0] & rx_line) | (r_smp[1] & rx_line))
        : rx_line;
    assign r_end = (r_sub == mid + 4'h1);

    always_comb begin
        next_rst_q = rst_q;
        next_r_sub = r_sub + 4'h1;
        next_r_bit = r_bit;
        next_r_sh = r_sh;
        next_r_zero = r_zero;
        next_r_par = r_par;
        next_r_sel = r_sel;
        next_r_smp = r_smp;
        if (r_sub == mid - 4'h1) next_r_smp[0] = rx_line;
        if (r_sub == mid) next_r_smp[1] = rx_line;
        if (r_sub == ovs_top) next_r_sub = 4'h0;
        ev = 7'h00;
        r_push = 1'b0;
        r_crc_c = 1'b0;
        case (rst_q)
            UAM_IDLE: begin
                next_r_sub = 4'h0;
                next_r_bit = 4'h0;
                next_r_zero = 1'b1;
                if (!rx_line) next_rst_q = UAM_START;
            end
            UAM_START: begin
                if (r_end) begin
                    if (r_val) next_rst_q = UAM_IDLE;
                    else next_rst_q = UAM_DATA;
                end
            end
            UAM_DATA: begin
                if (r_end) begin
                    r_crc_c = crc_enable;
                    next_r_sh = {r_val, r_sh[7:1]};
                    next_r_zero = r_zero & ~r_val;
                    next_r_bit = r_bit + 4'h1;
                    if (r_bit == `UAM_LAST_DATA_BIT) begin
                        next_rst_q = (addr_mode != UAM_ADDR_NONE) ?
                                     UAM_MARK : UAM_STOP;
                    end
                end
            end
            UAM_MARK: begin
                if (r_end) begin
                    next_r_par = r_val;
                    next_r_zero = r_zero & ~r_val;
                    next_rst_q = UAM_STOP;
                end
            end
            UAM_STOP: begin
                if (r_end) begin
                    next_rst_q = UAM_IDLE;
                    if (!r_val && r_zero && break_enable) begin
                        ev[`UAM_RX_BRK_BIT] = 1'b1;
                        next_rst_q = UAM_BREAK;
                    end else if (!r_val) begin
                        ev[`UAM_RX_STOP_BIT] = 1'b1;
                    end else if (r_par && addr_mode != UAM_ADDR_NONE) begin
                        ev[`UAM_RX_ADR_BIT] = 1'b1;
                        ev[`UAM_RX_PAR_BIT] = 1'b1;
                        next_r_sel = (r_sh == rx_addr1) ||
                            (!HALF_DUPLEX && r_sh == rx_addr2);
                        ev[`UAM_RX_HIT_BIT] = next_r_sel;
                        r_push = (addr_mode == UAM_ADDR_HW_BYTE) ?
                                 next_r_sel :
                                 (addr_mode != UAM_ADDR_HW_BUF);
                    end else begin
                        r_push = (addr_mode == UAM_ADDR_HW_BYTE ||
                                  addr_mode == UAM_ADDR_HW_BUF) ?
                                 r_sel : 1'b1;
                    end
                end
            end
            UAM_BREAK: begin
                if (rx_line) next_rst_q = UAM_IDLE;
            end
            default: next_rst_q = UAM_IDLE;
        endcase
        if (r_push && rx_cnt == 3'(DEPTH)) begin
            ev[`UAM_RX_OVR_BIT] = 1'b1;
            r_push = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rst_q <= UAM_IDLE;
            r_sub <= 4'h0;
            r_bit <= 4'h0;
            r_sh <= 8'h00;
            r_smp <= 2'h3;
            r_zero <= 1'b1;
            r_par <= 1'b0;
            r_sel <= 1'b0;
            rx_crc_clk <= 1'b0;
            rx_crc_data <= 1'b0;
        end else begin
            rst_q <= next_rst_q;
            r_sub <= next_r_sub;
            r_bit <= next_r_bit;
            r_sh <= next_r_sh;
            r_smp <= next_r_smp;
            r_zero <= next_r_zero;
            r_par <= next_r_par;
            r_sel <= next_r_sel;
            rx_crc_clk <= r_crc_c;
            rx_crc_data <= r_val;
        end
    end

    // ****************************************************************
    // FIFOs, status and interrupts.
    // ****************************************************************
    logic       rx_pop;
    logic [6:0] next_rx_status;
    assign rx_pop = rx_rd && (rx_cnt != 3'h0);
    assign next_tx_cnt = tx_cnt + 3'(tx_push) - 3'(tx_pop);
    assign next_rx_cnt = rx_cnt + 3'(r_push) - 3'(rx_pop);

    always_comb begin
        next_rx_status = rx_status;
        if (rx_status_clr) next_rx_status = 7'h00;
        next_rx_status = next_rx_status | ev;
        next_rx_status[`UAM_RX_NE_BIT] = (next_rx_cnt != 3'h0);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_cnt <= 3'h0;
            rx_cnt <= 3'h0;
            tx_rp <= 2'h0;
            tx_wp <= 2'h0;
            rx_rp <= 2'h0;
            rx_wp <= 2'h0;
            rx_status <= 7'h00;
            rx_rdata <= 8'h00;
        end else begin
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
            rx_status <= next_rx_status;
            if (tx_push) begin
                txq[tx_wp] <= tx_wdata;
                txq_mark[tx_wp] <= tx_wmark;
                tx_wp <= tx_wp + 2'h1;
            end
            if (tx_pop) tx_rp <= tx_rp + 2'h1;
            if (r_push) begin
                rxq[rx_wp] <= r_sh;
                rx_wp <= rx_wp + 2'h1;
            end
            if (rx_pop) begin
                rx_rdata <= rxq[rx_rp];
                rx_rp <= rx_rp + 2'h1;
            end
        end
    end

    always_comb begin
        tx_status = 4'h0;
        tx_status[`UAM_TX_DONE_BIT] = t_done;
        tx_status[`UAM_TX_EMPTY_BIT] = (tx_cnt == 3'h0);
        tx_status[`UAM_TX_FULL_BIT] = (tx_cnt == 3'(DEPTH));
        tx_status[`UAM_TX_ROOM_BIT] = (tx_cnt != 3'(DEPTH));
    end
    assign rx_interrupt = |(rx_status & rx_int_mask);
    assign tx_interrupt = !HALF_DUPLEX && |(tx_status & tx_int_mask);

    a_ovr_drop: assert property (
        ev[`UAM_RX_OVR_BIT] && !rx_pop |=>
        (rx_cnt == 3'(DEPTH)) && rx_status[`UAM_RX_OVR_BIT])
        else $error("overrun not flagged or char kept");
    a_rx_irq_or: assert property (
        (|(ev & rx_int_mask)) |=>
        rx_interrupt || (rx_int_mask != $past(rx_int_mask)))
        else $error("enabled rx event did not raise interrupt");
    a_tx_half: assert property (
        HALF_DUPLEX |-> !tx_interrupt)
        else $error("tx interrupt in half duplex");
    a_fifo_cap: assert property (
        tx_cnt <= 3'(DEPTH) && rx_cnt <= 3'(DEPTH))
        else $error("fifo count past depth");
    a_txen_busy: assert property (
        $fell(tx_line) |-> $past(tx_enable))
        else $error("line driven without enable");
    a_done_empty: assert property (
        $rose(t_done) |-> $past(tx_cnt) == 3'h0)
        else $error("complete with fifo not empty");
    a_none_noaddr: assert property (
        addr_mode == UAM_ADDR_NONE |-> !ev[`UAM_RX_ADR_BIT])
        else $error("address seen in mode none");
    a_bufmode_addr: assert property (
        (addr_mode == UAM_ADDR_HW_BUF && ev[`UAM_RX_ADR_BIT]) |-> !r_push)
        else $error("address byte stored in buffer mode");
endmodule

// [uam_map.svh]
`ifndef UAM_MAP_SVH
`define UAM_MAP_SVH
`define UAM_FIFO_DEPTH      4
`define UAM_OVS_8           4'h7
`define UAM_OVS_16          4'hf
`define UAM_BRK_MIN         4'hb
`define UAM_BRK_MAX         4'he
`define UAM_LAST_DATA_BIT   4'h7
`define UAM_RX_NE_BIT       0
`define UAM_RX_PAR_BIT      1
`define UAM_RX_STOP_BIT     2
`define UAM_RX_BRK_BIT      3
`define UAM_RX_OVR_BIT      4
`define UAM_RX_HIT_BIT      5
`define UAM_RX_ADR_BIT      6
`define UAM_TX_DONE_BIT     0
`define UAM_TX_EMPTY_BIT    1
`define UAM_TX_FULL_BIT     2
`define UAM_TX_ROOM_BIT     3
`endif

// [uam_pkg.sv]
package uam_pkg;
    typedef enum logic [2:0] {
        UAM_ADDR_NONE,
        UAM_ADDR_SW_BYTE,
        UAM_ADDR_SW_BUF,
        UAM_ADDR_HW_BYTE,
        UAM_ADDR_HW_BUF
    } uam_addr_mode_e;
    typedef enum {UAM_IDLE, UAM_START, UAM_DATA, UAM_MARK, UAM_STOP,
                  UAM_BREAK} uam_state_e;
endpackage

// [uam_peer.sv]
`timescale 1ns/100ps
// ********************
// Remote serial node.
// ********************
module uam_peer (
    input  wire logic       clk_sys,
    input  wire logic [4:0] bit_len,
    input  wire logic       mark_on,
    input  wire logic       tx_line,
    output logic            rx_line
);
    logic [8:0] got_q[$];
    logic [9:0] w;

    initial rx_line = 1'b1;

    // A one cycle inverted sample in mid bit stresses the majority vote.
    task automatic send(logic [7:0] d, logic mk, logic gl);
        logic [10:0] f;
        f = mark_on ? {1'b1, mk, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < (mark_on ? 11 : 10); i++) begin
            for (int c = 0; c < bit_len; c++) begin
                @(negedge clk_sys);
                rx_line = f[i] ^ (gl && c == bit_len / 2);
            end
        end
    endtask

    task automatic hold_low(int n);
        @(negedge clk_sys);
        rx_line = 1'b0;
        repeat (n * bit_len) @(negedge clk_sys);
        rx_line = 1'b1;
    endtask

    // Frames are decoded in mid bit; the stop is not kept.
    initial forever begin
        @(negedge tx_line);
        repeat (bit_len / 2) @(posedge clk_sys);
        for (int i = 0; i < (mark_on ? 10 : 9); i++) begin
            repeat (bit_len) @(posedge clk_sys);
            w[i] = tx_line;
        end
        got_q.push_back(mark_on ? w[8:0] : {1'b1, w[7:0]});
    end
endmodule

// [uam_top_bench.sv]
`timescale 1ns/100ps
`include "uam_map.svh"
`define CHK(n, e, s) begin \
    check_count++; \
    if ((s) !== (e)) begin \
        err_total++; \
        $display("[FAIL] %s expected %h seen %h", n, e, s); \
    end \
end
// ********************
// Bench.
// ********************
module uam_top_bench import uam_pkg::*;;
    uam_addr_mode_e addr_mode;
    logic [7:0]     rx_addr1, rx_addr2, tx_wdata, rx_rdata, a, d, e;
    logic [7:0]     lfsr, rx_crc, tx_crc;
    logic [3:0]     break_bits, tx_int_mask, tx_status;
    logic [6:0]     rx_int_mask, rx_status;
    logic           clk_sys, rst, ovs_sixteen, break_enable, vote_enable;
    logic           crc_enable, tx_wr, tx_wmark, tx_send_break, rx_rd;
    logic           rx_status_clr, rx_line, tx_line, tx_enable;
    logic           rx_interrupt, tx_interrupt, tx_crc_data, tx_crc_clk;
    logic           rx_crc_data, rx_crc_clk, rx_ck_q, tx_ck_q;
    logic [8:0]     sent_q[$];
    logic [4:0]     bl;
    int             err_total, check_count, rx_n, tx_n, n, rx_b, tx_b;

    assign bl = ovs_sixteen ? 5'h10 : 5'h08;
    uam_top i_uam_top (
        .clk_sys, .rst, .ovs_sixteen, .addr_mode, .rx_addr1, .rx_addr2,
        .break_enable, .break_bits, .vote_enable, .crc_enable,
        .rx_int_mask, .tx_int_mask, .tx_wr, .tx_wdata, .tx_wmark,
        .tx_send_break, .rx_rd, .rx_status_clr, .rx_line, .tx_line,
        .tx_enable, .rx_rdata, .rx_status, .tx_status, .rx_interrupt,
        .tx_interrupt, .tx_crc_data, .tx_crc_clk, .rx_crc_data, .rx_crc_clk
    );
    uam_peer i_uam_peer (
        .clk_sys, .bit_len(bl), .mark_on(addr_mode != UAM_ADDR_NONE),
        .tx_line, .rx_line
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ********************
    // Monitors.
    // ********************
    always @(negedge clk_sys) if (rst === 1'b0) begin
        `CHK("rx_irq", |(rx_status & rx_int_mask), rx_interrupt)
        `CHK("tx_irq", |(tx_status & tx_int_mask), tx_interrupt)
    end

    always @(posedge clk_sys) begin
        rx_ck_q <= rx_crc_clk;
        tx_ck_q <= tx_crc_clk;
        if (rx_crc_clk && !rx_ck_q) begin
            rx_crc <= {rx_crc_data, rx_crc[7:1]};
            rx_n <= rx_n + 1;
        end
        if (tx_crc_clk && !tx_ck_q) begin
            tx_crc <= {tx_crc_data, tx_crc[7:1]};
            tx_n <= tx_n + 1;
        end
    end

    // ********************
    // Tasks.
    // ********************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    task automatic idle(int c);
        repeat (c) @(negedge clk_sys);
    endtask

    task automatic push(logic [7:0] v, logic m);
        @(negedge clk_sys);
        tx_wr = 1'b1;
        tx_wdata = v;
        tx_wmark = m;
        @(negedge clk_sys);
        tx_wr = 1'b0;
    endtask

    task automatic pop_chk(logic [7:0] v);
        @(negedge clk_sys);
        rx_rd = 1'b1;
        @(negedge clk_sys);
        rx_rd = 1'b0;
        `CHK("rx_rdata", v, rx_rdata)
    endtask

    task automatic frame(logic [7:0] v, logic m);
        i_uam_peer.send(v, m, vote_enable);
        idle(3 * bl);
    endtask

    task automatic clr();
        @(negedge clk_sys);
        rx_status_clr = 1'b1;
        @(negedge clk_sys);
        rx_status_clr = 1'b0;
    endtask

    task automatic run_addr(uam_addr_mode_e m, logic [8:0] f[4],
                            logic [7:0] x[4], int nx);
        addr_mode = m;
        clr();
        foreach (f[i]) frame(f[i][7:0], f[i][8]);
        for (int i = 0; i < nx; i++) pop_chk(x[i]);
        `CHK("has_data", 1'b0, rx_status[`UAM_RX_NE_BIT])
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        final_report();
    end

    // ********************
    // Sequence.
    // ********************
    initial begin
        lfsr = 8'h5f;
        {tx_wr, tx_wmark, tx_send_break, rx_rd, rx_status_clr} = '0;
        {ovs_sixteen, break_enable, vote_enable, crc_enable} = '0;
        addr_mode = UAM_ADDR_NONE;
        break_bits = 4'hb;
        tx_wdata = 8'h00;
        rx_addr1 = rnd();
        rx_addr2 = rx_addr1 ^ 8'h01;
        a = rx_addr1 ^ 8'h80;
        rx_int_mask = 7'h00;
        tx_int_mask = 4'h0;
        rst = 1'b1;
        repeat (13) @(negedge clk_sys);
        rst = 1'b0;
        `CHK("tx_status", 4'ha, tx_status)
        `CHK("rx_status", 7'h00, rx_status)
        for (int o = 0; o < 2; o++) begin
            ovs_sixteen = o[0];
            rx_int_mask = 7'(rnd());
            tx_int_mask = 4'(rnd());
            for (int k = 0; k < 3; k++) begin
                d = rnd();
                frame(d, 1'b0);
                `CHK("has_data", 1'b1, rx_status[`UAM_RX_NE_BIT])
                pop_chk(d);
            end
        end
        addr_mode = UAM_ADDR_SW_BYTE;
        n = 0;
        while (tx_status[`UAM_TX_FULL_BIT] !== 1'b1 && n < 8) begin
            d = rnd();
            push(d, d[0]);
            sent_q.push_back({d[0], d});
            n++;
            `CHK("tx_enable", 1'b1, tx_enable)
        end
        `CHK("burst_len", 5, n)
        `CHK("has_room", 1'b0, tx_status[`UAM_TX_ROOM_BIT])
        push(8'h00, 1'b0);
        for (int t = 0; t < 300 && i_uam_peer.got_q.size() < n; t++) idle(bl);
        idle(2 * bl);
        foreach (sent_q[i])
            `CHK("tx_frame", sent_q[i], i_uam_peer.got_q[i])
        `CHK("tx_count", n, i_uam_peer.got_q.size())
        `CHK("tx_status", 4'hb, tx_status)
        `CHK("tx_enable", 1'b0, tx_enable)
        addr_mode = UAM_ADDR_NONE;
        clr();
        sent_q.delete();
        for (int k = 0; k < 5; k++) begin
            d = rnd();
            sent_q.push_back({1'b0, d});
            frame(d, 1'b0);
        end
        `CHK("overflow", 1'b1, rx_status[`UAM_RX_OVR_BIT])
        for (int k = 0; k < 4; k++) pop_chk(sent_q[k][7:0]);
        `CHK("has_data", 1'b0, rx_status[`UAM_RX_NE_BIT])
        d = rnd();
        e = rnd();
        run_addr(UAM_ADDR_SW_BYTE, '{{1'b1, a}, {1'b0, d},
                 {1'b1, rx_addr1}, {1'b0, e}}, '{a, d, rx_addr1, e}, 4);
        `CHK("addr_seen", 1'b1, rx_status[`UAM_RX_ADR_BIT])
        `CHK("mark_seen", 1'b1, rx_status[`UAM_RX_PAR_BIT])
        run_addr(UAM_ADDR_SW_BUF, '{{1'b1, a}, {1'b0, d},
                 {1'b1, a}, {1'b0, e}}, '{a, d, a, e}, 4);
        `CHK("addr_seen", 1'b1, rx_status[`UAM_RX_ADR_BIT])
        run_addr(UAM_ADDR_HW_BYTE, '{{1'b1, a}, {1'b0, d},
                 {1'b1, rx_addr2}, {1'b0, e}}, '{rx_addr2, e, d, d}, 2);
        `CHK("addr_hit", 1'b1, rx_status[`UAM_RX_HIT_BIT])
        run_addr(UAM_ADDR_HW_BUF, '{{1'b1, rx_addr1}, {1'b0, d},
                 {1'b1, a}, {1'b0, e}}, '{d, d, d, d}, 1);
        addr_mode = UAM_ADDR_NONE;
        vote_enable = 1'b1;
        for (int k = 0; k < 3; k++) begin
            d = rnd();
            frame(d, 1'b0);
            pop_chk(d);
        end
        vote_enable = 1'b0;
        crc_enable = 1'b1;
        rx_b = rx_n;
        tx_b = tx_n;
        d = rnd();
        e = rnd();
        push(e, 1'b0);
        frame(d, 1'b0);
        pop_chk(d);
        idle(12 * bl);
        `CHK("rx_crc_n", rx_b + 8, rx_n)
        `CHK("rx_crc", d, rx_crc)
        `CHK("tx_crc_n", tx_b + 8, tx_n)
        `CHK("tx_crc", e, tx_crc)
        clr();
        i_uam_peer.hold_low(12);
        idle(12 * bl);
        `CHK("framing", 1'b1, rx_status[`UAM_RX_STOP_BIT])
        `CHK("no_break", 1'b0, rx_status[`UAM_RX_BRK_BIT])
        break_enable = 1'b1;
        ovs_sixteen = 1'b0;
        clr();
        i_uam_peer.hold_low(12);
        idle(3 * bl);
        `CHK("break_seen", 1'b1, rx_status[`UAM_RX_BRK_BIT])
        for (int b = 11; b <= 14; b++) begin
            break_bits = 4'(b);
            tx_send_break = 1'b1;
            for (int t = 0; t < 64 && tx_line !== 1'b0; t++) idle(1);
            tx_send_break = 1'b0;
            n = 0;
            while (tx_line === 1'b0 && n < 300) begin
                idle(1);
                n++;
            end
            `CHK("break_len", b * bl, n)
            idle(2 * bl);
        end
        final_report();
    end
endmodule
